// [verilog/pdpc_regs.sv]
// wishbone register bank for the synth dividers, modulator and power control
//
// Operation
// R1 - power selector: 0 forced down, 1 forced up, 2 follows chip-enable pin
// R2 - writing one to soft reset bit restores every field to its default
// R3 - after reset each field holds its default until software writes it
// R4 - feedback divide is 18 bits over three byte registers, default 16
// R5 - writing the low feedback divide byte starts any configured ramp
// R6 - dither code: 0 weak, 1 medium, 2 strong, 3 none; default 0
// R7 - modulator order: 0 integer, 1 to 4 fractional orders, 5-7 reserved
// R8 - software keeps numerator no greater than the active denominator
// R9 - while ramping is enabled the denominator is fixed at two to 24
// R10 - reference divide defaults to 1 and value 1 bypasses the counter
// R11 - doubler enable bit puts a doubler ahead of the reference divider
// R12 - differential counter bit; software limits reference divide to 2,4,8
// R13 - pulse width code 1,2,3 gives 860, 1200, 1500 ps; default 1
// R14 - pump gain 0 tri-states, otherwise code times 100 uA
// R15 - pump polarity 0 negative, 1 positive
// R16 - software never writes reserved encodings
`include "pdpc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pdpc_regs
  import pdpc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [9:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic chip_enable_in,
  output logic powered_up_out,
  output logic [17:0] feedback_divide_out,
  output logic [1:0] modulator_dither_level_out,
  output logic [2:0] modulator_order_select_out,
  output logic [23:0] fraction_numerator_out,
  output logic [24:0] active_denominator_out,
  output logic [15:0] ref_divide_out,
  output logic ref_counter_bypass_out,
  output logic reference_doubler_enable_out,
  output logic differential_ref_counter_out,
  output logic [10:0] min_pulse_width_ps_out,
  output logic pump_tristate_out,
  output logic [11:0] pump_current_ua_out,
  output logic pump_polarity_select_out,
  output logic ramp_enable_out,
  output logic ramp_start_out
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  pdpc_state_t st;
  pdpc_state_t next_st;
  pdpc_state_t dflt;

  // derived outputs held in their own flops so every port is registered
  logic [24:0] den_q;
  logic [11:0] ua_q;
  logic [10:0] ps_q;
  logic bypass_q;
  logic tri_q;

  logic [7:0] idx;
  logic wr_hit;
  logic [7:0] wbyte;
  logic [31:0] rmux;

  assign idx = wb_adr_in[9:2];
  assign wbyte = wb_dat_in[7:0];
  // only the low byte lane holds register data
  assign wr_hit = wb_cyc_in && wb_stb_in && wb_we_in && wb_sel_in[0] &&
                  (st.bus == PDPC_BUS_IDLE);

  // ---------------------------------------------------------------------------
  // power-on defaults, used by soft reset; bus reset loads the same values directly
  // ---------------------------------------------------------------------------
  always_comb begin
    dflt = '0;
    dflt.bus = PDPC_BUS_IDLE;
    dflt.power_state_select = `PDPC_RST_POWER; // R3
    dflt.feedback_divide = `PDPC_RST_FBD; // R4
    dflt.modulator_dither_level = `PDPC_RST_DITHER;
    dflt.modulator_order_select = `PDPC_RST_ORDER;
    dflt.fraction_numerator = `PDPC_RST_NUM;
    dflt.fraction_denominator = `PDPC_RST_DEN;
    dflt.ref_divide = `PDPC_RST_REF; // R10
    dflt.min_pulse_width_select = `PDPC_RST_PULSE; // R13
    dflt.pump_current_gain = `PDPC_RST_GAIN;
  end

  // ---------------------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------------------
  always_comb begin
    rmux = 32'h00000000;
    unique case (idx)
      `PDPC_IDX_PWR: rmux[1:0] = st.power_state_select;
      `PDPC_IDX_FBD_LOW: rmux[7:0] = st.feedback_divide[7:0];
      `PDPC_IDX_FBD_MID: rmux[7:0] = st.feedback_divide[15:8];
      `PDPC_IDX_FBD_HIGH: rmux[6:0] = {st.modulator_order_select,
        st.modulator_dither_level, st.feedback_divide[17:16]};
      `PDPC_IDX_NUM0: rmux[7:0] = st.fraction_numerator[7:0];
      `PDPC_IDX_NUM1: rmux[7:0] = st.fraction_numerator[15:8];
      `PDPC_IDX_NUM2: rmux[7:0] = st.fraction_numerator[23:16];
      `PDPC_IDX_DEN0: rmux[7:0] = st.fraction_denominator[7:0];
      `PDPC_IDX_DEN1: rmux[7:0] = st.fraction_denominator[15:8];
      `PDPC_IDX_DEN2: rmux[7:0] = st.fraction_denominator[23:16];
      `PDPC_IDX_REF_LOW: rmux[7:0] = st.ref_divide[7:0];
      `PDPC_IDX_REF_HIGH: rmux[7:0] = st.ref_divide[15:8];
      // pulse width in [4:3], diff counter in [2], bit 1 reads zero
      `PDPC_IDX_REF_CFG: rmux[4:0] = {st.min_pulse_width_select,
        st.differential_ref_counter, 1'b0, st.reference_doubler_enable};
      `PDPC_IDX_PUMP: rmux[5:0] = {st.pump_polarity_select,
        st.pump_current_gain};
      `PDPC_IDX_STATUS: rmux[7:0] = st.ramp_start_count;
      `PDPC_IDX_RAMP_CTRL: rmux[0] = st.ramp_enable;
      default: rmux = 32'h00000000; // unmapped reads as zero, still acked
    endcase
    // live state in the status word: power level in bit 8
    if (idx == `PDPC_IDX_STATUS) begin
      rmux[8] = st.powered;
    end
  end

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.ramp_start = 1'b0;
    // chip-enable pin is asynchronous: two flops before anyone reads it
    next_st.chip_en_sync = {st.chip_en_sync[1:0], chip_enable_in};
    unique case (st.power_state_select)
      PDPC_PWR_FORCE_DOWN: next_st.powered = 1'b0; // R1
      PDPC_PWR_FORCE_UP: next_st.powered = 1'b1; // R1
      PDPC_PWR_FOLLOW_PIN: next_st.powered = st.chip_en_sync[1]; // R1
      // reserved code: stay down rather than guess
      default: next_st.powered = 1'b0;
    endcase

    // single cycle bus answer: ack one cycle after the strobe, then drop
    unique case (st.bus)
      PDPC_BUS_IDLE: begin
        if (wb_cyc_in && wb_stb_in) begin
          next_st.bus = PDPC_BUS_ACK;
          next_st.ack = 1'b1;
          next_st.rd_data = wb_we_in ? 32'h00000000 : rmux;
        end
      end
      PDPC_BUS_ACK: begin
        next_st.bus = PDPC_BUS_IDLE;
        next_st.ack = 1'b0;
      end
    endcase

    if (wr_hit) begin
      unique case (idx)
        `PDPC_IDX_PWR: begin
          next_st.power_state_select = wbyte[1:0];
        end
        `PDPC_IDX_FBD_LOW: begin
          next_st.feedback_divide[7:0] = wbyte; // R4
          next_st.ramp_start = st.ramp_enable; // R5
          next_st.ramp_start_count = st.ramp_start_count +
            {7'h00, st.ramp_enable};
        end
        `PDPC_IDX_FBD_MID: next_st.feedback_divide[15:8] = wbyte; // R4
        `PDPC_IDX_FBD_HIGH: begin
          next_st.feedback_divide[17:16] = wbyte[1:0]; // R4
          next_st.modulator_dither_level =
            wbyte[`PDPC_POS_DITHER_LO +: 2]; // R6
          next_st.modulator_order_select =
            wbyte[`PDPC_POS_ORDER_LO +: 3]; // R7
        end
        `PDPC_IDX_NUM0: next_st.fraction_numerator[7:0] = wbyte;
        `PDPC_IDX_NUM1: next_st.fraction_numerator[15:8] = wbyte;
        `PDPC_IDX_NUM2: next_st.fraction_numerator[23:16] = wbyte;
        `PDPC_IDX_DEN0: next_st.fraction_denominator[7:0] = wbyte;
        `PDPC_IDX_DEN1: next_st.fraction_denominator[15:8] = wbyte;
        `PDPC_IDX_DEN2: next_st.fraction_denominator[23:16] = wbyte;
        `PDPC_IDX_REF_LOW: next_st.ref_divide[7:0] = wbyte;
        `PDPC_IDX_REF_HIGH: next_st.ref_divide[15:8] = wbyte;
        `PDPC_IDX_REF_CFG: begin
          next_st.reference_doubler_enable = wbyte[`PDPC_POS_DOUBLER]; // R11
          next_st.differential_ref_counter = wbyte[`PDPC_POS_DIFF_REF]; // R12
          next_st.min_pulse_width_select =
            wbyte[`PDPC_POS_PULSE_LO +: 2]; // R13
        end
        `PDPC_IDX_PUMP: begin
          next_st.pump_current_gain = wbyte[4:0]; // R14
          next_st.pump_polarity_select = wbyte[`PDPC_POS_POLARITY]; // R15
        end
        `PDPC_IDX_RAMP_CTRL: next_st.ramp_enable = wbyte[0];
        default: begin
        end
      endcase
      // soft reset: all fields back to defaults; the bit itself self-clears
      if (idx == `PDPC_IDX_PWR && wbyte[`PDPC_POS_SOFT_RST]) begin
        next_st = dflt; // R2
        next_st.bus = PDPC_BUS_ACK;
        next_st.ack = 1'b1;
        next_st.chip_en_sync = st.chip_en_sync;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st <= '0;
      st.feedback_divide <= `PDPC_RST_FBD; // R3
      st.ref_divide <= `PDPC_RST_REF; // R3
      st.min_pulse_width_select <= `PDPC_RST_PULSE; // R3
      den_q <= 25'h0000000;
      ua_q <= 12'h000;
      ps_q <= `PDPC_PS_860;
      bypass_q <= 1'b1;
      tri_q <= 1'b1;
    end else begin
      st <= next_st;
      // ramping forces the fixed denominator regardless of the register
      den_q <= next_st.ramp_enable ? `PDPC_RAMP_DEN :
        {1'b0, next_st.fraction_denominator}; // R9
      ua_q <= 12'(next_st.pump_current_gain * `PDPC_PUMP_STEP_UA); // R14
      tri_q <= (next_st.pump_current_gain == 5'h00); // R14
      bypass_q <= (next_st.ref_divide == 16'h0001); // R10
      unique case (next_st.min_pulse_width_select)
        2'h2: ps_q <= `PDPC_PS_1200; // R13
        2'h3: ps_q <= `PDPC_PS_1500; // R13
        // reserved code 0 falls back to the recommended width
        default: ps_q <= `PDPC_PS_860; // R13
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // outputs, all straight from flops
  // ---------------------------------------------------------------------------
  assign wb_dat_out = st.rd_data;
  assign wb_ack_out = st.ack;
  assign powered_up_out = st.powered;
  assign feedback_divide_out = st.feedback_divide;
  assign modulator_dither_level_out = st.modulator_dither_level; // R6
  assign modulator_order_select_out = st.modulator_order_select; // R7
  assign fraction_numerator_out = st.fraction_numerator;
  assign active_denominator_out = den_q;
  assign ref_divide_out = st.ref_divide;
  assign ref_counter_bypass_out = bypass_q;
  assign reference_doubler_enable_out = st.reference_doubler_enable;
  assign differential_ref_counter_out = st.differential_ref_counter;
  assign min_pulse_width_ps_out = ps_q;
  assign pump_tristate_out = tri_q;
  assign pump_current_ua_out = ua_q;
  assign pump_polarity_select_out = st.pump_polarity_select;
  assign ramp_enable_out = st.ramp_enable;
  assign ramp_start_out = st.ramp_start;

endmodule
`default_nettype wire

// [verilog/pdpc_cfg.svh]
// register offsets, field positions, reset values and widths for the synth config bank
`ifndef PDPC_CFG_SVH
`define PDPC_CFG_SVH
// ---------------------------------------------------------------------------
// register indices (byte address = 4 * index)
// ---------------------------------------------------------------------------
`define PDPC_IDX_PWR 8'h02
`define PDPC_IDX_FBD_LOW 8'h10
`define PDPC_IDX_FBD_MID 8'h11
`define PDPC_IDX_FBD_HIGH 8'h12
`define PDPC_IDX_NUM0 8'h13
`define PDPC_IDX_NUM1 8'h14
`define PDPC_IDX_NUM2 8'h15
`define PDPC_IDX_DEN0 8'h16
`define PDPC_IDX_DEN1 8'h17
`define PDPC_IDX_DEN2 8'h18
`define PDPC_IDX_REF_LOW 8'h19
`define PDPC_IDX_REF_HIGH 8'h1a
`define PDPC_IDX_REF_CFG 8'h1b
`define PDPC_IDX_PUMP 8'h1c
`define PDPC_IDX_STATUS 8'h1d
`define PDPC_IDX_RAMP_CTRL 8'h1e
// ---------------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------------
`define PDPC_POS_SOFT_RST 2
`define PDPC_POS_DOUBLER 0
`define PDPC_POS_DIFF_REF 2
`define PDPC_POS_PULSE_LO 3
`define PDPC_POS_POLARITY 5
`define PDPC_POS_DITHER_LO 2
`define PDPC_POS_ORDER_LO 4
// ---------------------------------------------------------------------------
// power-on defaults
// ---------------------------------------------------------------------------
`define PDPC_RST_POWER 2'h0
`define PDPC_RST_FBD 18'h00010
`define PDPC_RST_DITHER 2'h0
`define PDPC_RST_ORDER 3'h0
`define PDPC_RST_NUM 24'h000000
`define PDPC_RST_DEN 24'h000000
`define PDPC_RST_REF 16'h0001
`define PDPC_RST_PULSE 2'h1
`define PDPC_RST_GAIN 5'h00
// ---------------------------------------------------------------------------
// fixed values
// ---------------------------------------------------------------------------
`define PDPC_RAMP_DEN 25'h1000000
`define PDPC_PUMP_STEP_UA 100
`define PDPC_PS_860 11'd860
`define PDPC_PS_1200 11'd1200
`define PDPC_PS_1500 11'd1500
`endif

// [verilog/pdpc_pkg.sv]
// types for the synth divider and power config bank
package pdpc_pkg;
  typedef enum logic [1:0] {
    PDPC_PWR_FORCE_DOWN,
    PDPC_PWR_FORCE_UP,
    PDPC_PWR_FOLLOW_PIN,
    PDPC_PWR_RESERVED
  } pdpc_power_mode_t;

  typedef enum logic [1:0] {
    PDPC_DITHER_WEAK,
    PDPC_DITHER_MEDIUM,
    PDPC_DITHER_STRONG,
    PDPC_DITHER_NONE
  } pdpc_dither_t;

  typedef enum {
    PDPC_BUS_IDLE,
    PDPC_BUS_ACK
  } pdpc_bus_state_t;

  typedef struct packed {
    pdpc_bus_state_t bus;
    logic [31:0] rd_data;
    logic ack;
    logic [1:0] power_state_select;
    logic [17:0] feedback_divide;
    logic [1:0] modulator_dither_level;
    logic [2:0] modulator_order_select;
    logic [23:0] fraction_numerator;
    logic [23:0] fraction_denominator;
    logic [15:0] ref_divide;
    logic reference_doubler_enable;
    logic differential_ref_counter;
    logic [1:0] min_pulse_width_select;
    logic [4:0] pump_current_gain;
    logic pump_polarity_select;
    logic ramp_enable;
    logic ramp_start;
    logic [7:0] ramp_start_count;
    logic [2:0] chip_en_sync;
    logic powered;
  } pdpc_state_t;
endpackage

// [verif/pdpc_regs_properties.sv]
// concurrent checks on the synth config bank ports
`timescale 1ns/1ps
`default_nettype none
module pdpc_regs_properties (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [9:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic wb_ack_out,
  input wire logic [17:0] feedback_divide_out,
  input wire logic [24:0] active_denominator_out,
  input wire logic [15:0] ref_divide_out,
  input wire logic ref_counter_bypass_out,
  input wire logic [10:0] min_pulse_width_ps_out,
  input wire logic pump_tristate_out,
  input wire logic [11:0] pump_current_ua_out,
  input wire logic ramp_enable_out,
  input wire logic ramp_start_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // ---------------------------------------------------------------
  // bus sequences: a taken request, then a low feedback byte write
  // ---------------------------------------------------------------
  sequence s_take;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_fbd_write;
    s_take ##0 (wb_we_in && wb_sel_in[0] && wb_adr_in[9:2] == 8'h10);
  endsequence
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  a_ack_after_take: assert property (s_take |=> wb_ack_out)
    else $error("no ack one cycle after request");
  a_ack_one_cycle: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack stood longer than one cycle");
  a_fbd_low_lands: assert property (s_fbd_write |=>
    feedback_divide_out[7:0] == $past(wb_dat_in[7:0]))
    else $error("low feedback byte not written");
  a_start_on_fbd: assert property (s_fbd_write ##0 ramp_enable_out
    |=> ramp_start_out && wb_ack_out)
    else $error("ramp start missing after low byte write");
  a_start_has_cause: assert property (ramp_start_out |->
    $past(wb_we_in && wb_adr_in[9:2] == 8'h10) ##1 !ramp_start_out)
    else $error("ramp start without low byte write");
  a_ramp_den_fixed: assert property (ramp_enable_out |->
    active_denominator_out == 25'h1000000)
    else $error("denominator not fixed while ramping");
  a_bypass_ref_one: assert property (ref_counter_bypass_out ==
    (ref_divide_out == 16'h0001))
    else $error("bypass does not match divide of one");
  a_pump_current: assert property (pump_tristate_out ==
    (pump_current_ua_out == 12'h000) && pump_current_ua_out % 100 == 0
    && pump_current_ua_out <= 12'd3100)
    else $error("pump current not a legal step");
  a_pulse_legal: assert property (min_pulse_width_ps_out inside
    {11'd860, 11'd1200, 11'd1500})
    else $error("pulse width not a listed value");
  a_reset_defaults: assert property ($past(rst_in) |->
    feedback_divide_out == 18'h00010 && ref_divide_out == 16'h0001
    && !ramp_enable_out)
    else $error("fields not at defaults after reset");
endmodule
bind pdpc_regs pdpc_regs_properties u_props (.clk_sys_in, .rst_in,
  .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in,
  .wb_ack_out, .feedback_divide_out, .active_denominator_out,
  .ref_divide_out, .ref_counter_bypass_out, .min_pulse_width_ps_out,
  .pump_tristate_out, .pump_current_ua_out, .ramp_enable_out,
  .ramp_start_out);
`default_nettype wire

// [verif/pdpc_regs_bench.sv]
// self-checking bench for the synth config register bank
`timescale 1ns/1ps
`default_nettype none
module pdpc_regs_bench;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ce = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, dat_o;
  logic ack, pwr, bypass, dbl, diff, tri_s, pol, ren, rstart;
  logic [17:0] fbd;
  logic [1:0] dith;
  logic [2:0] ord;
  logic [23:0] num;
  logic [24:0] den;
  logic [15:0] refd;
  logic [10:0] ps;
  logic [11:0] ua;
  int errors = 0, compares = 0, starts = 0;
  logic [7:0] idx_t [14] = '{8'h02, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
    8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c};
  logic [7:0] def_t [14] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h08, 8'h00};
  logic [7:0] val_t [14] = '{8'h01, 8'h34, 8'h12, 8'h4a, 8'h11, 8'h22,
    8'h33, 8'h44, 8'h55, 8'h66, 8'h08, 8'h00, 8'h1d, 8'h3f};
  pdpc_regs DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(dat_o),
    .wb_ack_out(ack), .chip_enable_in(ce), .powered_up_out(pwr),
    .feedback_divide_out(fbd), .modulator_dither_level_out(dith),
    .modulator_order_select_out(ord), .fraction_numerator_out(num),
    .active_denominator_out(den), .ref_divide_out(refd),
    .ref_counter_bypass_out(bypass), .reference_doubler_enable_out(dbl),
    .differential_ref_counter_out(diff), .min_pulse_width_ps_out(ps),
    .pump_tristate_out(tri_s), .pump_current_ua_out(ua),
    .pump_polarity_select_out(pol), .ramp_enable_out(ren),
    .ramp_start_out(rstart));
  // free-running clock and the ramp start pulse counter
  initial begin
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  // counted on the falling edge so the count settles before any check
  always @(negedge clk_sys_in) begin
    if (rstart === 1'b1) starts++;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // one classic cycle; request held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] d, input logic s0);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= {3'b000, s0};
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n == 50) chk(32'h0, 32'h1);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 1'b1);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00, 1'b1);
    chk(rdat, exp);
  endtask
  // fixed settle time covers the pin's two sync flops
  task automatic pw(input logic [7:0] code, input logic c, input logic e);
    wr(8'h02, code);
    ce <= c;
    repeat (8) @(posedge clk_sys_in);
    chk(pwr, e);
  endtask
  task automatic complete_run;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int i;
    int g;
    repeat (6) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    for (i = 0; i < 14; i++) rd(idx_t[i], def_t[i]);
    chk(ps, 11'd860);
    for (i = 0; i < 14; i++) wr(idx_t[i], val_t[i]);
    for (i = 0; i < 14; i++) rd(idx_t[i], val_t[i]);
    chk(fbd, 18'h21234);
    chk(num, 24'h332211);
    chk(den, 25'h0665544);
    chk(refd, 16'h0008);
    chk({dbl, diff, bypass, pol, tri_s}, 5'b11010);
    chk(ps, 11'd1500);
    chk(ua, 12'd3100);
    for (i = 0; i < 5; i++) begin
      wr(8'h12, {1'b0, i[2:0], i[1:0], 2'b10});
      chk(ord, i[2:0]);
      chk(dith, i[1:0]);
    end
    for (i = 1; i < 4; i++) begin
      wr(8'h1b, {3'b000, i[1:0], 3'b000});
      chk(ps, (i == 1) ? 860 : (i == 2) ? 1200 : 1500);
    end
    for (i = 0; i < 4; i++) begin
      g = (i == 3) ? 31 : i;
      wr(8'h1c, g[7:0]);
      chk(ua, g * 100);
      chk({tri_s, pol}, {g == 0, 1'b0});
    end
    wr(8'h19, 8'h01);
    chk(bypass, 1'b1);
    wr(8'h1a, 8'h01);
    chk(bypass, 1'b0);
    rd(8'h40, 32'h0);
    wr(8'h40, 8'hff);
    bus(1'b1, 8'h19, 8'h77, 1'b0);
    rd(8'h19, 32'h01);
    pw(8'h00, 1'b1, 1'b0);
    pw(8'h01, 1'b0, 1'b1);
    pw(8'h02, 1'b1, 1'b1);
    pw(8'h02, 1'b0, 1'b0);
    pw(8'h01, 1'b0, 1'b1);
    wr(8'h1e, 8'h01);
    chk(den, 25'h1000000);
    wr(8'h10, 8'h20);
    chk(starts, 1);
    rd(8'h1d, 32'h101);
    wr(8'h1e, 8'h00);
    wr(8'h10, 8'h21);
    chk({starts[7:0], den}, {8'h01, 25'h0665544});
    wr(8'h1e, 8'h01);
    wr(8'h02, 8'h05);
    for (i = 0; i < 14; i++) rd(idx_t[i], def_t[i]);
    chk({ren, fbd, refd}, {1'b0, 18'h00010, 16'h0001});
    complete_run();
  end
  // watchdog far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    errors++;
    complete_run();
  end
endmodule
`default_nettype wire
